/* core/rshc_holdoff.sv */
`timescale 1ns/1ps
`default_nettype none
module rshc_holdoff #(
  parameter int DIV_W = 18
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // control
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [DIV_W-1:0] divider,
  input  wire logic [7:0]       start_value,
  // one-cycle pulse at the zero transition
  output var  logic             expire
);
  logic [DIV_W-1:0] div_cnt;
  logic [7:0]       cnt;
  logic             step;

  // a divider of zero is served as divide-by-one
  assign step = run && tick && (div_cnt + DIV_W'(1) >= divider);

  // idle keeps the prescaler cleared so nothing is clocked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
    end else if (!run || step) begin
      div_cnt <= '0;
    end else if (tick) begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt    <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (!run) begin
        cnt <= start_value;
      end else if (step) begin
        if (cnt <= 8'h01) begin
          expire <= 1'b1;
          cnt    <= start_value;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule : rshc_holdoff
`default_nettype wire

/* core/rshc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rshc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // pins in, filtered levels out
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit only moves once the second and third stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule : rshc_sync
`default_nettype wire

/* core/rshc_top.sv */
// Function
// - short-term mode: lost reference holds, revalidation relocks
// - short-term mode: manual reselect switches without holdover
// - auto-holdover: loss or reselect holds, counter fails over
// - holdover lasts start value times divider ticks
// - auto-holdover: revalidation or reselect ends holdover early
// - auto-holdover: expiry without valid input keeps holdover, selection
// - holdover output uses stored earlier frequency word
// - forced holdover configurations select no input
// - manual holdover: change holds until counter expires
// - manual holdover: flags low, selection updates after
// - active reference loss drops reference status at once
// - both inputs keep being monitored during countdown
// - revalidation during countdown keeps selection, ignores revertive
// - auto-holdover: expiry with revalidated reference keeps it, ends hold
// - auto-holdover: expiry with other input valid switches to it
// - eight-bit down counter on divided VCXO ticks
// - counter reloads start value after expiry
// - divider runs only during counted holdover
// - loss latch re-arms only after software clears
// - revertive switching returns to the input named by internal_select
// - first PLL lock lost above phase window unless VCXO control setting is set
// - second PLL lock reported, latched, on pin
// - latched bits clear by one, refuse while fault
// - enabled latched bits drive active-low interrupt
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module rshc_top #(
  parameter int DIV_W = 18
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // pins from the monitors and the VCXO divider
  input  wire logic [1:0]  LOS_IN,
  input  wire logic        VCXO_DIV_CLK,
  input  wire logic        SECOND_LOCK_IN,
  // same-clock loop signals
  input  wire logic [15:0] PHASE_DIFF,
  input  wire logic [15:0] FREQ_WORD,
  // reference control and status
  output var  logic        SELECTED_INPUT,
  output var  logic        REF_ENABLE,
  output var  logic        HOLDOVER_ACTIVE,
  output var  logic [15:0] HOLD_WORD,
  output var  logic        LOCK_V,
  output var  logic        INTERRUPT_OUT_LOW
);

  if (DIV_W < 1 || DIV_W > 24) begin : g_chk
    $error("DIV_W must lie in 1..24");
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and bus

  rshc_pkg::rshc_ctrl_t      ctrl;
  rshc_pkg::rshc_state_t     state;
  logic [7:0]                holdoff_start_value;
  logic [DIV_W-1:0]          holdoff_divider;
  logic [7:0]                revalidation_count;
  logic [14:0]               phase_window_threshold;
  logic [5:0]                interrupt_enable_bits;
  logic [5:0]                lat;
  logic [5:0]                fault;
  logic [3:0]                pin_s;
  logic [1:0]                valid;
  logic [7:0]                rv_cnt [2];
  logic                      sel;
  logic                      pend;
  logic                      last_int_sel;
  logic                      vcxo_prev;
  logic                      tick;
  logic                      expire;
  logic                      run;
  logic                      forced_cfg;
  logic                      direct_cfg;
  logic                      chg;
  logic                      ref_status_now;
  logic                      first_pll_lock_now;
  logic                      second_pll_lock_now;
  logic                      acc;
  logic                      wr;
  logic [31:0]               rd_word;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = a == rshc_pkg::OFF_CTRL || a == rshc_pkg::OFF_HOLDOFF ||
              a == rshc_pkg::OFF_REVAL || a == rshc_pkg::OFF_THRESH ||
              a == rshc_pkg::OFF_STATUS || a == rshc_pkg::OFF_LATCHED ||
              a == rshc_pkg::OFF_IE;
  endfunction : reg_hit

  assign acc = PSEL && PENABLE && PREADY;
  assign wr  = acc && PWRITE && reg_hit(PADDR);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (PADDR)
      rshc_pkg::OFF_CTRL:    rd_word = {24'h00_0000, ctrl};
      rshc_pkg::OFF_HOLDOFF: rd_word = {{(24 - DIV_W){1'b0}}, holdoff_divider, holdoff_start_value};
      rshc_pkg::OFF_REVAL:   rd_word = {24'h00_0000, revalidation_count};
      rshc_pkg::OFF_THRESH:  rd_word = {17'h0_0000, phase_window_threshold};
      rshc_pkg::OFF_STATUS:  rd_word = {25'h000_0000, ref_status_now, sel,
                                        state == rshc_pkg::ST_TRACK,
                                        second_pll_lock_now, first_pll_lock_now, valid};
      rshc_pkg::OFF_LATCHED: rd_word = {26'h000_0000, lat};
      rshc_pkg::OFF_IE:      rd_word = {26'h000_0000, interrupt_enable_bits};
      default:               rd_word = 32'h0000_0000;
    endcase
  end

  // zero wait states: ready rises in the first access cycle
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !reg_hit(PADDR);
      if (PSEL && !PENABLE) begin
        PRDATA <= rd_word;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl                   <= rshc_pkg::CTRL_RST;
      holdoff_start_value    <= rshc_pkg::HOLDOFF_RST[rshc_pkg::HOLDOFF_START_LSB +: 8];
      holdoff_divider        <= rshc_pkg::HOLDOFF_RST[rshc_pkg::HOLDOFF_DIV_LSB +: DIV_W];
      revalidation_count     <= rshc_pkg::REVAL_RST;
      phase_window_threshold <= rshc_pkg::THRESH_RST;
      interrupt_enable_bits  <= rshc_pkg::IE_RST;
    end else if (wr) begin
      case (PADDR)
        rshc_pkg::OFF_CTRL:    ctrl <= PWDATA[7:0];
        rshc_pkg::OFF_HOLDOFF: begin
          holdoff_start_value <= PWDATA[rshc_pkg::HOLDOFF_START_LSB +: 8];
          holdoff_divider     <= PWDATA[rshc_pkg::HOLDOFF_DIV_LSB +: DIV_W];
        end
        rshc_pkg::OFF_REVAL:   revalidation_count <= PWDATA[7:0];
        rshc_pkg::OFF_THRESH:  phase_window_threshold <= PWDATA[14:0];
        rshc_pkg::OFF_IE:      interrupt_enable_bits <= PWDATA[5:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input monitoring

  rshc_sync #(.W(4)) u_sync (
    .clk  (CORE_CLK),
    .rst  (RST),
    .din  ({SECOND_LOCK_IN, VCXO_DIV_CLK, LOS_IN}),
    .dout (pin_s)
  );

  assign tick = pin_s[2] && !vcxo_prev;

  // revalidation counts core cycles of clean input, not input edges
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      valid     <= 2'b00;
      rv_cnt    <= '{8'h00, 8'h00};
      vcxo_prev <= 1'b0;
    end else begin
      vcxo_prev <= pin_s[2];
      for (int i = 0; i < 2; i++) begin
        if (pin_s[i]) begin
          valid[i]  <= 1'b0;
          rv_cnt[i] <= 8'h00;
        end else if (rv_cnt[i] >= revalidation_count) begin
          valid[i] <= 1'b1;
        end else begin
          rv_cnt[i] <= rv_cnt[i] + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference selection

  assign forced_cfg = ctrl.external_select_field == rshc_pkg::EXT_FORCE ||
                      (ctrl.external_select_field == rshc_pkg::EXT_INTERNAL &&
                       !ctrl.manual_auto_enable);
  assign direct_cfg = !forced_cfg && ctrl.external_select_field != rshc_pkg::EXT_INTERNAL;
  assign chg        = ctrl.internal_select != last_int_sel;
  assign run        = state == rshc_pkg::ST_HOLD && !forced_cfg && !direct_cfg &&
                      (ctrl.switch_mode_bits == rshc_pkg::MODE_AUTO_HLD ||
                       ctrl.switch_mode_bits == rshc_pkg::MODE_MANUAL_HLD);
  assign ref_status_now = state == rshc_pkg::ST_TRACK && valid[sel];

  rshc_holdoff #(.DIV_W(DIV_W)) u_holdoff (
    .clk         (CORE_CLK),
    .rst         (RST),
    .run         (run),
    .tick        (tick),
    .divider     (holdoff_divider),
    .start_value (holdoff_start_value),
    .expire      (expire)
  );

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state        <= rshc_pkg::ST_TRACK;
      sel          <= 1'b0;
      pend         <= 1'b0;
      last_int_sel <= 1'b0;
    end else begin
      last_int_sel <= ctrl.internal_select;
      if (forced_cfg) begin
        state <= rshc_pkg::ST_FORCED;
      end else if (direct_cfg) begin
        state <= rshc_pkg::ST_TRACK;
        sel   <= ctrl.external_select_field[0];
      end else begin
        case (ctrl.switch_mode_bits)
          rshc_pkg::MODE_MANUAL_HLD: begin
            if (chg) begin
              state <= rshc_pkg::ST_HOLD;
              pend  <= ctrl.internal_select;
            end else if (state != rshc_pkg::ST_HOLD) begin
              state <= rshc_pkg::ST_TRACK;
            end else if (expire) begin
              state <= rshc_pkg::ST_TRACK;
              sel   <= pend;
            end
          end
          rshc_pkg::MODE_AUTO: begin
            state <= rshc_pkg::ST_TRACK;
            if (chg) begin
              sel <= ctrl.internal_select;
            end else if (!valid[sel] && valid[!sel]) begin
              sel <= !sel;
            end else if (ctrl.revertive_enable && valid[ctrl.internal_select]) begin
              sel <= ctrl.internal_select;
            end
          end
          rshc_pkg::MODE_SHORT: begin
            if (chg) begin
              state <= rshc_pkg::ST_TRACK;
              sel   <= ctrl.internal_select;
            end else if (valid[sel]) begin
              state <= rshc_pkg::ST_TRACK;
            end else begin
              state <= rshc_pkg::ST_HOLD;
            end
          end
          default: begin
            if (state != rshc_pkg::ST_HOLD) begin
              state <= rshc_pkg::ST_TRACK;
              if (chg) begin
                state <= rshc_pkg::ST_HOLD;
                pend  <= ctrl.internal_select;
              end else if (!valid[sel]) begin
                state <= rshc_pkg::ST_HOLD;
                pend  <= sel;
              end else if (ctrl.revertive_enable && valid[ctrl.internal_select]) begin
                sel <= ctrl.internal_select;
              end
            end else if (chg) begin
              state <= rshc_pkg::ST_TRACK;
              sel   <= ctrl.internal_select;
            end else if (pend == sel && valid[sel]) begin
              state <= rshc_pkg::ST_TRACK;
            end else if (expire) begin
              if (valid[pend]) begin
                state <= rshc_pkg::ST_TRACK;
                sel   <= pend;
              end else if (valid[!pend]) begin
                state <= rshc_pkg::ST_TRACK;
                sel   <= !pend;
              end else begin
                state <= rshc_pkg::ST_HOLD;
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock detect, latched flags, outputs

  assign second_pll_lock_now = pin_s[3];

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      first_pll_lock_now <= 1'b1;
    end else begin
      first_pll_lock_now <= ctrl.vcxo_control_setting ||
                            PHASE_DIFF <= {1'b0, phase_window_threshold};
    end
  end

  assign fault = {!ref_status_now, state != rshc_pkg::ST_TRACK,
                  !second_pll_lock_now, !first_pll_lock_now, ~valid};

  // set wins over a clear, so a live fault re-latches at once
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      lat <= 6'h00;
    end else if (wr && PADDR == rshc_pkg::OFF_LATCHED) begin
      lat <= (lat & ~PWDATA[5:0]) | fault;
    end else begin
      lat <= lat | fault;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      INTERRUPT_OUT_LOW <= 1'b1;
      LOCK_V            <= 1'b0;
      SELECTED_INPUT    <= 1'b0;
      REF_ENABLE        <= 1'b1;
      HOLDOVER_ACTIVE   <= 1'b0;
    end else begin
      INTERRUPT_OUT_LOW <= !(|(lat & interrupt_enable_bits));
      LOCK_V            <= second_pll_lock_now;
      SELECTED_INPUT    <= sel;
      REF_ENABLE        <= state != rshc_pkg::ST_FORCED;
      HOLDOVER_ACTIVE   <= state != rshc_pkg::ST_TRACK;
    end
  end

  // frozen word while holding; the loop runs on it instead of the reference
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      HOLD_WORD <= 16'h0000;
    end else if (state == rshc_pkg::ST_TRACK) begin
      HOLD_WORD <= FREQ_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  logic auto_hold;
  assign auto_hold = !forced_cfg && !direct_cfg &&
                     ctrl.switch_mode_bits == rshc_pkg::MODE_AUTO_HLD;

  property p_forced;
    forced_cfg |=> state == rshc_pkg::ST_FORCED ##1 HOLDOVER_ACTIVE && !REF_ENABLE;
  endproperty
  a_forced: assert property (p_forced) else $error("forced config not held");

  property p_short_loss;
    !forced_cfg && !direct_cfg && ctrl.switch_mode_bits == rshc_pkg::MODE_SHORT &&
    !chg && !valid[sel] |=> state == rshc_pkg::ST_HOLD ##1 HOLDOVER_ACTIVE;
  endproperty
  a_short_loss: assert property (p_short_loss) else $error("short hold missed");

  property p_loss_ref_low;
    auto_hold && state == rshc_pkg::ST_TRACK && !chg && !valid[sel]
      |=> !ref_status_now && state == rshc_pkg::ST_HOLD ##1 lat[rshc_pkg::BIT_REF];
  endproperty
  a_loss_ref_low: assert property (p_loss_ref_low) else $error("ref status not low");

  property p_expire_none;
    auto_hold && state == rshc_pkg::ST_HOLD && !chg && expire && valid == 2'b00
      |=> state == rshc_pkg::ST_HOLD && $stable(sel);
  endproperty
  a_expire_none: assert property (p_expire_none) else $error("hold left with no input");

  property p_expire_other;
    auto_hold && state == rshc_pkg::ST_HOLD && !chg && expire && !valid[pend] &&
    valid[!pend] && !(pend == sel && valid[sel]) |=> sel == !$past(pend) && ref_status_now;
  endproperty
  a_expire_other: assert property (p_expire_other) else $error("no failover");

  property p_manual_wait;
    !forced_cfg && !direct_cfg && ctrl.switch_mode_bits == rshc_pkg::MODE_MANUAL_HLD &&
    state == rshc_pkg::ST_HOLD && !expire |=> $stable(sel);
  endproperty
  a_manual_wait: assert property (p_manual_wait) else $error("early manual switch");

  property p_sticky;
    lat[rshc_pkg::BIT_IN0] && !(wr && PADDR == rshc_pkg::OFF_LATCHED)
      |=> lat[rshc_pkg::BIT_IN0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("latched bit lost");

  property p_refuse_clear;
    wr && PADDR == rshc_pkg::OFF_LATCHED && PWDATA[rshc_pkg::BIT_IN0] && !valid[0]
      |=> lat[rshc_pkg::BIT_IN0];
  endproperty
  a_refuse_clear: assert property (p_refuse_clear) else $error("clear took with fault");

  property p_int;
    |(lat & interrupt_enable_bits) |=> !INTERRUPT_OUT_LOW;
  endproperty
  a_int: assert property (p_int) else $error("interrupt not raised");

  property p_lolv;
    !ctrl.vcxo_control_setting && PHASE_DIFF > {1'b0, phase_window_threshold}
      |=> !first_pll_lock_now ##1 lat[rshc_pkg::BIT_LOLV];
  endproperty
  a_lolv: assert property (p_lolv) else $error("loss of lock missed");

  property p_no_run;
    !run |=> !expire;
  endproperty
  a_no_run: assert property (p_no_run) else $error("counter ran idle");

  c_hold_entry: cover property (auto_hold && state == rshc_pkg::ST_TRACK ##1
                                state == rshc_pkg::ST_HOLD);
  c_failover:   cover property (auto_hold && expire ##1 $changed(sel));
  c_forced:     cover property (forced_cfg ##1 state == rshc_pkg::ST_FORCED);
  c_int:        cover property ($fell(INTERRUPT_OUT_LOW));

endmodule : rshc_top
`default_nettype wire

/* shared/rshc_pkg.sv */
package rshc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_HOLDOFF = 8'h04;
  localparam logic [7:0] OFF_REVAL   = 8'h08;
  localparam logic [7:0] OFF_THRESH  = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_LATCHED = 8'h14;
  localparam logic [7:0] OFF_IE      = 8'h18;

  // holdoff register fields
  localparam int HOLDOFF_START_LSB = 0;
  localparam int HOLDOFF_DIV_LSB   = 8;

  // status / latched / enable bit positions
  localparam int BIT_IN0  = 0;
  localparam int BIT_IN1  = 1;
  localparam int BIT_LOLV = 2;
  localparam int BIT_LOLF = 3;
  localparam int BIT_HOLD = 4;
  localparam int BIT_REF  = 5;
  localparam int BIT_SEL  = 5;
  localparam int BIT_RNOW = 6;
  localparam int NFLAG    = 6;

  // external selection and switch mode encodings
  localparam logic [1:0] EXT_INTERNAL    = 2'h2;
  localparam logic [1:0] EXT_FORCE       = 2'h3;
  localparam logic [1:0] MODE_MANUAL_HLD = 2'h0;
  localparam logic [1:0] MODE_AUTO       = 2'h1;
  localparam logic [1:0] MODE_SHORT      = 2'h2;
  localparam logic [1:0] MODE_AUTO_HLD   = 2'h3;

  typedef struct packed {
    logic       vcxo_control_setting;
    logic       revertive_enable;
    logic       internal_select;
    logic [1:0] switch_mode_bits;
    logic       manual_auto_enable;
    logic [1:0] external_select_field;
  } rshc_ctrl_t;

  // reset values
  localparam rshc_ctrl_t  CTRL_RST    = 8'h06;
  localparam logic [31:0] HOLDOFF_RST = 32'h0200_000F;
  localparam logic [7:0]  REVAL_RST   = 8'h10;
  localparam logic [14:0] THRESH_RST  = 15'h0100;
  localparam logic [5:0]  IE_RST      = 6'h00;

  typedef enum logic [1:0] {
    ST_TRACK  = 2'b00,
    ST_HOLD   = 2'b01,
    ST_FORCED = 2'b11
  } rshc_state_t;

endpackage : rshc_pkg

/* verif/reference_select_holdover_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module reference_select_holdover_ctrl_tb;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [1:0]  drop = 0, los;
  logic [15:0] freq = 16'h1234, hold_word, pdiff = 0;
  logic        div_clk, sel, ref_en, hold, lock_v, int_n, e, lock2 = 1;
  int          n_mismatch = 0, checks = 0;
  always #2.5 clk = ~clk;
  rshc_ref_model PM (.clk(clk), .rst(rst), .drop(drop), .los(los), .div_clk(div_clk));
  rshc_top DUT (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LOS_IN(los), .VCXO_DIV_CLK(div_clk), .SECOND_LOCK_IN(lock2), .PHASE_DIFF(pdiff),
    .FREQ_WORD(freq), .SELECTED_INPUT(sel), .REF_ENABLE(ref_en), .HOLDOVER_ACTIVE(hold),
    .HOLD_WORD(hold_word), .LOCK_V(lock_v), .INTERRUPT_OUT_LOW(int_n));
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic t_regs;
    apb(0, rshc_pkg::OFF_CTRL, 0);    `CHK("ctrl", 32'h0000_0006, q)
    apb(0, rshc_pkg::OFF_HOLDOFF, 0); `CHK("holdoff", rshc_pkg::HOLDOFF_RST, q)
    apb(0, rshc_pkg::OFF_IE, 0);      `CHK("ie", 32'h0000_0000, q)
    apb(0, 8'h1C, 0);                 `CHK("slverr", 1'b1, e)
    $display("regs done");
  endtask : t_regs
  task automatic t_irq;
    apb(1, rshc_pkg::OFF_LATCHED, 32'h0000_003F);
    drop <= 2'h2;
    wt(10);
    apb(1, rshc_pkg::OFF_IE, 32'h0000_0002);
    wt(2);                            `CHK("int", 1'b0, int_n)
    apb(1, rshc_pkg::OFF_LATCHED, 32'h0000_0002);
    apb(0, rshc_pkg::OFF_LATCHED, 0); `CHK("stuck", 1'b1, q[1])
    apb(1, rshc_pkg::OFF_IE, 32'h0000_0000);
    wt(2);                            `CHK("int off", 1'b1, int_n)
    drop <= 2'h0;
    wt(40);
    apb(1, rshc_pkg::OFF_LATCHED, 32'h0000_003F);
    apb(0, rshc_pkg::OFF_LATCHED, 0); `CHK("cleared", 1'b0, q[1])
    $display("irq done");
  endtask : t_irq
  task automatic t_auto;
    int n;
    apb(1, rshc_pkg::OFF_HOLDOFF, 32'h0000_0202);
    apb(1, rshc_pkg::OFF_CTRL, 32'h0000_001E);
    wt(10);
    drop <= 2'h1;
    for (n = 0; n < 50 && hold !== 1'b1; n++) wt(1);
    `CHK("hold", 1'b1, hold)
    `CHK("sel kept", 1'b0, sel)
    freq <= 16'hABCD;
    apb(0, rshc_pkg::OFF_STATUS, 0);  `CHK("ref now", 1'b0, q[6])
    `CHK("frozen", 16'h1234, hold_word)
    for (n = 0; n < 400 && hold === 1'b1; n++) wt(1);
    `CHK("dur", 1'b1, n >= 20 && n <= 48)
    `CHK("failover", 1'b1, sel)
    drop <= 2'h0;
    $display("auto done");
  endtask : t_auto
  task automatic t_forced;
    apb(1, rshc_pkg::OFF_CTRL, 32'h0000_0007);
    wt(4);
    `CHK("no ref", 1'b0, ref_en)
    `CHK("forced", 1'b1, hold)
    apb(1, rshc_pkg::OFF_CTRL, 32'h0000_001E);
    wt(4);                            `CHK("ref back", 1'b1, ref_en)
    $display("forced done");
  endtask : t_forced
  task automatic t_short;
    apb(1, rshc_pkg::OFF_CTRL, 32'h0000_0016);
    wt(30);
    drop <= 2'h2;
    wt(12);                           `CHK("short hold", 1'b1, hold)
    drop <= 2'h0;
    wt(40);                           `CHK("relock", 1'b0, hold)
    apb(1, rshc_pkg::OFF_CTRL, 32'h0000_0036);
    drop <= 2'h1;
    wt(12);
    apb(1, rshc_pkg::OFF_CTRL, 32'h0000_0016);
    wt(3);                            `CHK("direct", 1'b0, sel)
    drop <= 2'h0;
    $display("short done");
  endtask : t_short
  task automatic t_manual;
    int n;
    apb(1, rshc_pkg::OFF_CTRL, 32'h0000_0006);
    wt(60);
    apb(1, rshc_pkg::OFF_CTRL, 32'h0000_0026);
    wt(4);                            `CHK("man hold", 1'b1, hold)
    `CHK("man wait", 1'b0, sel)
    apb(0, rshc_pkg::OFF_STATUS, 0);  `CHK("hold flag", 2'b00, q[5:4])
    for (n = 0; n < 100 && hold === 1'b1; n++) wt(1);
    `CHK("man switch", 1'b1, sel)
    $display("manual done");
  endtask : t_manual
  task automatic t_lock;
    apb(1, rshc_pkg::OFF_LATCHED, 32'h0000_000C);
    pdiff <= 16'h0200;
    lock2 <= 1'b0;
    wt(8);                            `CHK("lock pin", 1'b0, lock_v)
    apb(0, rshc_pkg::OFF_STATUS, 0);  `CHK("lock now", 2'b00, q[3:2])
    pdiff <= 16'h0000;
    lock2 <= 1'b1;
    wt(8);                            `CHK("lock back", 1'b1, lock_v)
    apb(1, rshc_pkg::OFF_LATCHED, 32'h0000_0003);
    apb(0, rshc_pkg::OFF_LATCHED, 0); `CHK("lock sticky", 2'b11, q[3:2])
    apb(1, rshc_pkg::OFF_LATCHED, 32'h0000_000C);
    apb(0, rshc_pkg::OFF_LATCHED, 0); `CHK("lock clear", 2'b00, q[3:2])
    $display("lock done");
  endtask : t_lock
  initial begin
    wt(16);
    rst <= 1'b0;
    wt(40);
    t_regs();
    t_irq();
    t_auto();
    t_forced();
    t_short();
    t_manual();
    t_lock();
    wrap_up();
  end
  initial begin
    wt(20000);
    n_mismatch++;
    wrap_up();
  end
endmodule : reference_select_holdover_ctrl_tb
`default_nettype wire

/* verif/rshc_ref_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rshc_ref_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // commanded outages, pins out
  input  wire logic [1:0] drop,
  output var  logic [1:0] los,
  output var  logic       div_clk
);
  logic [1:0] cnt;
  // the divided vcxo runs free, it is not framed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt     <= 2'h0;
      div_clk <= 1'h0;
    end else begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h3) div_clk <= ~div_clk;
    end
  end
  always_ff @(posedge clk) los <= drop;
endmodule : rshc_ref_model
`default_nettype wire
